// file: design/pmic_cfg_pkg.sv
package pmic_cfg_pkg;

  // offsets are not multiples of four: index kept, byte address is 4 * index
  localparam logic [11:0] IDX_PAUSE_CFG = 12'h097;
  localparam logic [11:0] IDX_RELEASE_CFG = 12'h099;
  localparam logic [11:0] IDX_B2_ILIM = 12'h09A;
  localparam logic [11:0] IDX_B3_ILIM = 12'h09B;
  localparam logic [11:0] IDX_B1_ILIM = 12'h09C;
  localparam logic [11:0] IDX_B1_CFG = 12'h09E;
  localparam logic [11:0] IDX_B3_CFG = 12'h09F;
  localparam logic [11:0] IDX_B2_CFG = 12'h0A0;
  localparam logic [11:0] IDX_B1_VA = 12'h0A4;
  localparam logic [11:0] IDX_B3_VA = 12'h0A5;
  localparam logic [11:0] IDX_B2_VA = 12'h0A7;
  // registers of our own: pause slot index, sequencer status
  localparam logic [11:0] IDX_PAUSE_SLOT = 12'h0C0;
  localparam logic [11:0] IDX_STATUS = 12'h0C1;

  localparam logic [7:0] RST_PAUSE_CFG = 8'h00;
  localparam logic [7:0] RST_RELEASE_CFG = 8'h00;
  localparam logic [7:0] RST_ILIM = 8'h00;
  localparam logic [7:0] RST_BUCK_CFG = 8'h00;
  localparam logic [7:0] RST_VOLT_A = 8'h00;
  localparam logic [7:0] RST_PAUSE_SLOT = 8'h00;

  // field positions
  localparam int DIR_HI = 7;
  localparam int DIR_LO = 6;
  localparam int LIMIT_EN_BIT = 5;
  localparam int SRC_BIT = 4;
  localparam int HOLD_HI = 3;
  localparam int EVT_HI = 7;
  localparam int EVT_LO = 6;
  localparam int DELAY_HI = 5;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int DISCH_BIT = 5;
  localparam int SLEEP_BIT = 7;
  localparam int VCODE_HI = 6;

  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;

  typedef enum logic [1:0] {
    OPM_BY_SETTING = 2'b00,
    OPM_PFM = 2'b01,
    OPM_PWM = 2'b10,
    OPM_AUTO = 2'b11
  } opmode_t;

  typedef enum logic [1:0] {
    TRG_WAKE = 2'b00,
    TRG_SYS = 2'b01,
    TRG_PWR = 2'b10,
    TRG_RESET_EXIT = 2'b11
  } trig_t;

  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BASE_TICK_NS = 1024;
  localparam int BASE_TICK_CYC = BASE_TICK_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int HOLD_BASE_US = 512;
  localparam int HOLD_BASE_CYC = HOLD_BASE_US * (CLK_HZ / 1_000_000);
  localparam int EXT_LIMIT_MS = 500;
  localparam int EXT_LIMIT_CYC = EXT_LIMIT_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [1:0] opmode;
    logic discharge_off;
    logic sleep_a;
    logic [6:0] vcode;
    logic [3:0] ilim;
  } buck_ctl_t;

  typedef struct packed {
    logic pfm;
    logic pwm;
    logic pulldown_en;
    logic [6:0] vcode;
    logic [3:0] ilim;
    logic half_ilim;
  } buck_drive_t;

endpackage

// file: design/buck_ctl_decode.sv
`timescale 1ns/1ps
module buck_ctl_decode
  import pmic_cfg_pkg::*;
(
  input wire buck_ctl_t ctl,
  input wire logic a_active,
  input wire logic sleep_b,
  input wire logic enabled,
  input wire logic halve,
  output buck_drive_t drive
);
  logic sel_sleep;

  always_comb begin
    sel_sleep = a_active ? ctl.sleep_a : sleep_b;
    drive.pfm = 1'b0;
    drive.pwm = 1'b0;
    case (opmode_t'(ctl.opmode))
      OPM_BY_SETTING: begin
        drive.pfm = sel_sleep;
        drive.pwm = ~sel_sleep;
      end
      OPM_PFM: drive.pfm = 1'b1;
      OPM_PWM: drive.pwm = 1'b1;
      OPM_AUTO: begin
        drive.pfm = 1'b1;
        drive.pwm = 1'b1;
      end
      default: drive.pwm = 1'b1;
    endcase
    drive.pulldown_en = ~enabled & ~ctl.discharge_off;
    drive.vcode = ctl.vcode;
    drive.ilim = ctl.ilim;
    drive.half_ilim = halve;
  end
endmodule

// file: design/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [31:0] count,
  output logic busy,
  output logic done
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= count;
        busy <= (count != 32'h0);
        done <= (count == 32'h0);
      end else if (busy) begin
        if (cnt_r <= 32'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r - 32'h1;
      end
    end
  end
endmodule

// file: design/pmic_seq_wait_buck_ctrl.sv
`timescale 1ns/1ps
module pmic_seq_wait_buck_ctrl
  import pmic_cfg_pkg::*;
#(
  parameter logic [7:0] PAUSE_CFG_INIT = RST_PAUSE_CFG,
  parameter logic [7:0] RELEASE_CFG_INIT = RST_RELEASE_CFG,
  parameter logic [7:0] ILIM_INIT = RST_ILIM,
  parameter logic [7:0] BUCK_CFG_INIT = RST_BUCK_CFG,
  parameter logic [7:0] VOLT_A_INIT = RST_VOLT_A,
  parameter logic [7:0] PAUSE_SLOT_INIT = RST_PAUSE_SLOT,
  parameter int HOLD_BASE_CYCLES = HOLD_BASE_CYC,
  parameter int EXT_LIMIT_CYCLES = EXT_LIMIT_CYC,
  parameter int RELEASE_TICK_CYCLES = BASE_TICK_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [13:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [13:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SEQ_AT_STEP,
  input wire logic [3:0] SEQ_STEP,
  input wire logic SEQ_DIR_DOWN,
  output logic SEQ_HOLD,
  input wire logic PAUSE_INPUT_PIN,
  input wire logic EXTERNAL_WAKE_EVENT,
  input wire logic SYSTEM_DOMAIN_RISE,
  input wire logic POWER_DOMAIN_RISE,
  input wire logic RESET_MODE_EXIT,
  output logic SYSTEM_RESET_OUT_N,
  input wire logic [2:0] BUCK_ENABLED,
  input wire logic B_SETTING_ACTIVE,
  input wire logic [2:0] BUCK_SLEEP_B,
  input wire logic FIRST_BUCK_HALF_CURRENT,
  output buck_drive_t FIRST_BUCK_DRIVE,
  output buck_drive_t SECOND_BUCK_DRIVE,
  output buck_drive_t THIRD_BUCK_DRIVE
);

  logic [7:0] pause_cfg_r, release_cfg_r, pause_slot_r;
  logic [7:0] ilim_r [3];
  logic [7:0] bcfg_r [3];
  logic [7:0] volt_r [3];

  // 1 = first, 2 = second, 3 = third buck; 0 = not a buck register
  function automatic logic [1:0] buck_of(input logic [11:0] idx);
    case (idx)
      IDX_B1_ILIM, IDX_B1_CFG, IDX_B1_VA: buck_of = 2'h1;
      IDX_B2_ILIM, IDX_B2_CFG, IDX_B2_VA: buck_of = 2'h2;
      IDX_B3_ILIM, IDX_B3_CFG, IDX_B3_VA: buck_of = 2'h3;
      default: buck_of = 2'h0;
    endcase
  endfunction

  // 0 = current limit, 1 = config, 2 = A voltage; inputs only, so usable in assigns
  function automatic logic [1:0] kind_of(input logic [11:0] idx);
    case (idx)
      IDX_B1_CFG, IDX_B2_CFG, IDX_B3_CFG: kind_of = 2'h1;
      IDX_B1_VA, IDX_B2_VA, IDX_B3_VA: kind_of = 2'h2;
      default: kind_of = 2'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] idx);
    mapped = (buck_of(idx) != 2'h0) || idx == IDX_PAUSE_CFG ||
             idx == IDX_RELEASE_CFG || idx == IDX_PAUSE_SLOT || idx == IDX_STATUS;
  endfunction

  // ---- write channel: address and data taken in either order
  logic aw_held_r, w_held_r;
  logic [11:0] aw_idx_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic do_write;
  logic [1:0] wb, wk;
  logic wmap;

  assign S_AXI_AWREADY = ~aw_held_r & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_held_r & ~S_AXI_BVALID;
  assign do_write = aw_held_r & w_held_r & ~S_AXI_BVALID;
  assign wb = buck_of(aw_idx_r);
  assign wk = kind_of(aw_idx_r);
  assign wmap = mapped(aw_idx_r) && aw_idx_r != IDX_STATUS;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 12'h000;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= S_AXI_AWADDR[13:2];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_r <= 1'b1;
        wdata_r <= S_AXI_WDATA[7:0];
        wstrb0_r <= S_AXI_WSTRB[0];
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wmap ? 2'h0 : 2'h2;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ---- register store; reads give back what was written, except pause slot, which keeps only bits 3:0
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pause_cfg_r <= PAUSE_CFG_INIT;
      release_cfg_r <= RELEASE_CFG_INIT;
      pause_slot_r <= PAUSE_SLOT_INIT;
      for (int i = 0; i < 3; i++) begin
        ilim_r[i] <= ILIM_INIT;
        bcfg_r[i] <= BUCK_CFG_INIT;
        volt_r[i] <= VOLT_A_INIT;
      end
    end else if (do_write && wstrb0_r) begin
      if (aw_idx_r == IDX_PAUSE_CFG) pause_cfg_r <= wdata_r;
      if (aw_idx_r == IDX_RELEASE_CFG) release_cfg_r <= wdata_r;
      if (aw_idx_r == IDX_PAUSE_SLOT) pause_slot_r <= {4'h0, wdata_r[3:0]};
      if (wb != 2'h0) begin
        case (wk)
          2'h0: ilim_r[wb - 2'h1] <= wdata_r;
          2'h1: bcfg_r[wb - 2'h1] <= wdata_r;
          default: volt_r[wb - 2'h1] <= wdata_r;
        endcase
      end
    end
  end

  // ---- read channel
  logic [7:0] status;
  logic [1:0] rb, rk;
  logic [11:0] ridx;
  logic [7:0] rval;

  assign ridx = S_AXI_ARADDR[13:2];
  assign rb = buck_of(ridx);
  assign rk = kind_of(ridx);
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always_comb begin
    rval = 8'h00;
    if (ridx == IDX_PAUSE_CFG) rval = pause_cfg_r;
    else if (ridx == IDX_RELEASE_CFG) rval = release_cfg_r;
    else if (ridx == IDX_PAUSE_SLOT) rval = pause_slot_r;
    else if (ridx == IDX_STATUS) rval = status;
    else if (rb != 2'h0) begin
      case (rk)
        2'h0: rval = ilim_r[rb - 2'h1];
        2'h1: rval = bcfg_r[rb - 2'h1];
        default: rval = volt_r[rb - 2'h1];
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h0, rval};
      S_AXI_RRESP <= mapped(ridx) ? 2'h0 : 2'h2;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ---- pin synchronisers
  logic [4:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else begin
      pin_s1_r <= {RESET_MODE_EXIT, POWER_DOMAIN_RISE, SYSTEM_DOMAIN_RISE,
                   EXTERNAL_WAKE_EVENT, PAUSE_INPUT_PIN};
      pin_s2_r <= pin_s1_r;
    end
  end

  // ---- sequencer pause
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_PIN = 2'b01,
    P_TIMED = 2'b10,
    P_DONE = 2'b11
  } pause_st_t;
  pause_st_t pst_r;
  logic want_wait, hold_done, hold_start, lim_done;
  logic [3:0] hold_code;
  logic [31:0] hold_cyc;

  assign hold_code = pause_cfg_r[HOLD_HI:0];
  assign want_wait = SEQ_AT_STEP && SEQ_STEP == pause_slot_r[3:0] &&
    (SEQ_DIR_DOWN ? pause_cfg_r[DIR_LO + 1] : pause_cfg_r[DIR_LO]);
  // 512 us doubling per code; the printed figures are rounded and within 10 %
  assign hold_cyc = 32'(HOLD_BASE_CYCLES) << (hold_code - 4'h1);
  assign hold_start = pst_r == P_IDLE && want_wait && pause_cfg_r[SRC_BIT] &&
                      hold_code != 4'h0;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pst_r <= P_IDLE;
    end else begin
      case (pst_r)
        P_IDLE: if (want_wait) begin
          if (!pause_cfg_r[SRC_BIT]) pst_r <= P_PIN;
          else if (hold_code != 4'h0) pst_r <= P_TIMED;
          else pst_r <= P_DONE;
        end
        P_PIN: if (pin_s2_r[0] || (pause_cfg_r[LIMIT_EN_BIT] && lim_done))
          pst_r <= P_DONE;
        P_TIMED: if (hold_done) pst_r <= P_DONE;
        P_DONE: if (!SEQ_AT_STEP) pst_r <= P_IDLE;
        default: pst_r <= P_IDLE;
      endcase
    end
  end

  // hold also covers the idle cycle so the sequencer never slips past the step
  assign SEQ_HOLD = (pst_r == P_PIN) || (pst_r == P_TIMED) ||
                    (pst_r == P_IDLE && want_wait &&
                     !(pause_cfg_r[SRC_BIT] && hold_code == 4'h0));

  cycle_timer u_hold (
    .clk(CORE_CLK), .rst(RESET), .start(hold_start), .count(hold_cyc),
    .busy(), .done(hold_done)
  );
  cycle_timer u_limit (
    .clk(CORE_CLK), .rst(RESET),
    .start(pst_r == P_IDLE && want_wait && !pause_cfg_r[SRC_BIT]),
    .count(32'(EXT_LIMIT_CYCLES)), .busy(), .done(lim_done)
  );

  // ---- reset release
  logic [4:0] trig_d_r;
  logic trig_sel, trig_pulse, rel_busy, rel_done;
  logic [5:0] dly;
  logic [31:0] rel_cyc;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) trig_d_r <= 5'h00;
    else trig_d_r <= pin_s2_r;
  end

  always_comb begin
    case (trig_t'(release_cfg_r[EVT_HI:EVT_LO]))
      TRG_WAKE: trig_sel = pin_s2_r[1] & ~trig_d_r[1];
      TRG_SYS: trig_sel = pin_s2_r[2] & ~trig_d_r[2];
      TRG_PWR: trig_sel = pin_s2_r[3] & ~trig_d_r[3];
      TRG_RESET_EXIT: trig_sel = pin_s2_r[4] & ~trig_d_r[4];
      default: trig_sel = 1'b0;
    endcase
  end
  assign trig_pulse = trig_sel;
  assign dly = release_cfg_r[DELAY_HI:0];
  assign rel_cyc = (dly < 6'd32) ?
    32'(RELEASE_TICK_CYCLES) * 32'(dly) :
    32'(RELEASE_TICK_CYCLES) * 32'd32 * 32'(dly - 6'd31);

  cycle_timer u_release (
    .clk(CORE_CLK), .rst(RESET), .start(trig_pulse), .count(rel_cyc),
    .busy(rel_busy), .done(rel_done)
  );

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) SYSTEM_RESET_OUT_N <= 1'b0;
    else if (rel_done) SYSTEM_RESET_OUT_N <= 1'b1;
  end

  assign status = {4'h0, SYSTEM_RESET_OUT_N, rel_busy, pst_r};

  // ---- buck drives
  buck_ctl_t c1, c2, c3;
  assign c1 = '{bcfg_r[0][MODE_HI:MODE_LO], bcfg_r[0][DISCH_BIT], volt_r[0][SLEEP_BIT],
                volt_r[0][VCODE_HI:0], ilim_r[0][3:0]};
  assign c2 = '{bcfg_r[1][MODE_HI:MODE_LO], bcfg_r[1][DISCH_BIT], volt_r[1][SLEEP_BIT],
                volt_r[1][VCODE_HI:0], ilim_r[1][3:0]};
  assign c3 = '{bcfg_r[2][MODE_HI:MODE_LO], bcfg_r[2][DISCH_BIT], volt_r[2][SLEEP_BIT],
                volt_r[2][VCODE_HI:0], ilim_r[2][3:0]};

  buck_ctl_decode u_b1 (
    .ctl(c1), .a_active(~B_SETTING_ACTIVE), .sleep_b(BUCK_SLEEP_B[0]),
    .enabled(BUCK_ENABLED[0]), .halve(FIRST_BUCK_HALF_CURRENT), .drive(FIRST_BUCK_DRIVE)
  );
  buck_ctl_decode u_b2 (
    .ctl(c2), .a_active(~B_SETTING_ACTIVE), .sleep_b(BUCK_SLEEP_B[1]),
    .enabled(BUCK_ENABLED[1]), .halve(1'b0), .drive(SECOND_BUCK_DRIVE)
  );
  buck_ctl_decode u_b3 (
    .ctl(c3), .a_active(~B_SETTING_ACTIVE), .sleep_b(BUCK_SLEEP_B[2]),
    .enabled(BUCK_ENABLED[2]), .halve(1'b0), .drive(THIRD_BUCK_DRIVE)
  );

endmodule

// file: test/seq_cfg_monitor.sv
`timescale 1ns/1ps
module seq_cfg_monitor
  import pmic_cfg_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SEQ_AT_STEP,
  input wire logic SEQ_HOLD,
  input wire logic SYSTEM_RESET_OUT_N,
  input wire logic FIRST_BUCK_HALF_CURRENT,
  input wire buck_drive_t FIRST_BUCK_DRIVE,
  input wire buck_drive_t SECOND_BUCK_DRIVE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence rd_answer;
    S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h000000;
  endsequence
  read_answer_a:
    assert property (rd_taken |=> rd_answer)
    else $error("read answer missing");
  read_stall_a:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data moved while stalled");
  resp_stall_a:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response moved while stalled");
  read_refuse_a:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while answer pending");
  release_sticky_a:
    assert property (SYSTEM_RESET_OUT_N |=> SYSTEM_RESET_OUT_N)
    else $error("reset output dropped after release");
  mode_any_a:
    assert property ((FIRST_BUCK_DRIVE.pfm || FIRST_BUCK_DRIVE.pwm) &&
      (SECOND_BUCK_DRIVE.pfm || SECOND_BUCK_DRIVE.pwm))
    else $error("buck left without operating mode");
  half_flag_a:
    assert property (FIRST_BUCK_DRIVE.half_ilim == FIRST_BUCK_HALF_CURRENT)
    else $error("half current flag wrong");
  hold_at_step_a:
    assert property ($rose(SEQ_HOLD) |-> SEQ_AT_STEP)
    else $error("hold raised off a step");
endmodule

bind pmic_seq_wait_buck_ctrl seq_cfg_monitor mon (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .SEQ_AT_STEP(SEQ_AT_STEP), .SEQ_HOLD(SEQ_HOLD), .SYSTEM_RESET_OUT_N(SYSTEM_RESET_OUT_N),
  .FIRST_BUCK_HALF_CURRENT(FIRST_BUCK_HALF_CURRENT),
  .FIRST_BUCK_DRIVE(FIRST_BUCK_DRIVE), .SECOND_BUCK_DRIVE(SECOND_BUCK_DRIVE)
);

// file: test/seq_walker.sv
`timescale 1ns/1ps
module seq_walker (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic down,
  input wire logic hold,
  output logic at_step,
  output logic [3:0] step,
  output logic dir_down,
  output logic busy,
  output int held
);
  // one cycle a step; a held step never advances
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      step <= 4'h0;
      dir_down <= 1'b0;
      held <= 0;
    end else if (go) begin
      busy <= 1'b1;
      step <= down ? 4'h8 : 4'h1;
      dir_down <= down;
      held <= 0;
    end else if (!busy) begin
      // idle step lines carry no value, so keep them moving
      step <= ~step;
    end else if (hold) begin
      held <= held + 1;
    end else if (step == (dir_down ? 4'h1 : 4'h8)) begin
      busy <= 1'b0;
    end else begin
      step <= dir_down ? step - 4'h1 : step + 4'h1;
    end
  end
  assign at_step = busy;
endmodule

// file: test/pmic_seq_wait_buck_ctrl_test.sv
`timescale 1ns/1ps
module pmic_seq_wait_buck_ctrl_test
  import pmic_cfg_pkg::*;
;
  localparam int HB = 8;
  localparam int EL = 50;
  localparam int RT = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic awr, wrd, bv, arr, rv, at, dd, hold, busy, rel_n;
  logic [1:0] bresp, rresp;
  logic go = 0, down = 0, pin = 0, ba = 0, half = 0;
  logic [3:0] trg = '0, stp;
  logic [2:0] en = '0, slb = '0;
  int held;
  int failures = 0, total_checks = 0;
  buck_drive_t drv [3];
  logic [33:0] exp_q [$];
  logic [31:0] lf = 32'h8A56;
  logic [11:0] regs [12] = '{IDX_PAUSE_CFG, IDX_RELEASE_CFG, IDX_B2_ILIM, IDX_B3_ILIM,
    IDX_B1_ILIM, IDX_B1_CFG, IDX_B3_CFG, IDX_B2_CFG, IDX_B1_VA, IDX_B3_VA, IDX_B2_VA,
    IDX_PAUSE_SLOT};
  logic [7:0] msk [12] = '{8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'hE0, 8'hE0, 8'hE0,
    8'hFF, 8'hFF, 8'hFF, 8'h0F};
  logic [11:0] cfg_i [3] = '{IDX_B1_CFG, IDX_B2_CFG, IDX_B3_CFG};
  logic [11:0] va_i [3] = '{IDX_B1_VA, IDX_B2_VA, IDX_B3_VA};
  logic [11:0] il_i [3] = '{IDX_B1_ILIM, IDX_B2_ILIM, IDX_B3_ILIM};
  logic [5:0] codes [5] = '{6'h00, 6'h03, 6'h1F, 6'h20, 6'h21};

  always #5 clk = ~clk;

  pmic_seq_wait_buck_ctrl #(.HOLD_BASE_CYCLES(HB), .EXT_LIMIT_CYCLES(EL),
    .RELEASE_TICK_CYCLES(RT)) DUT (
    .CORE_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .SEQ_AT_STEP(at),
    .SEQ_STEP(stp), .SEQ_DIR_DOWN(dd), .SEQ_HOLD(hold), .PAUSE_INPUT_PIN(pin),
    .EXTERNAL_WAKE_EVENT(trg[0]), .SYSTEM_DOMAIN_RISE(trg[1]), .POWER_DOMAIN_RISE(trg[2]),
    .RESET_MODE_EXIT(trg[3]), .SYSTEM_RESET_OUT_N(rel_n), .BUCK_ENABLED(en),
    .B_SETTING_ACTIVE(ba), .BUCK_SLEEP_B(slb), .FIRST_BUCK_HALF_CURRENT(half),
    .FIRST_BUCK_DRIVE(drv[0]), .SECOND_BUCK_DRIVE(drv[1]), .THIRD_BUCK_DRIVE(drv[2])
  );

  seq_walker walker (.clk(clk), .rst(rst), .go(go), .down(down), .hold(hold), .at_step(at),
    .step(stp), .dir_down(dd), .busy(busy), .held(held));

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] ex);
    total_checks++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && n < 300);
    bready <= 1'b0;
    chk({n < 300, bresp}, {1'b1, er});
    // let an edge pass so a following call never re-raises bready in this time step
    tick(1);
  endtask

  task automatic rd(input logic [11:0] i, input logic [33:0] ex);
    int n;
    n = 0;
    exp_q.push_back(ex);
    araddr <= {i, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 300);
    rready <= 1'b0;
    chk(n < 300, 1);
    tick(1);
  endtask

  // the answer is judged where it appears, against the oldest note
  always @(posedge clk) if (rv && rready) chk({rresp, rdata}, exp_q.pop_front());

  task automatic walk(input logic [7:0] c, input logic [3:0] slot, input logic dn,
    input int pd, input int lo, input int hi);
    int n;
    n = 0;
    wr(IDX_PAUSE_SLOT, {4'h0, slot}, 2'h0);
    wr(IDX_PAUSE_CFG, c, 2'h0);
    go <= 1'b1;
    down <= dn;
    tick(1);
    go <= 1'b0;
    tick(1);
    while (busy && n < 400) begin
      n++;
      if (held == pd) pin <= 1'b1;
      tick(1);
    end
    pin <= 1'b0;
    chk(held >= lo && held <= hi && n < 400, 1);
  endtask

  task automatic rel_test(input logic [1:0] t, input logic [5:0] c);
    int n, e;
    e = c == 0 ? 0 : (c < 32 ? c * RT : RT * 32 * (c - 31));
    n = 0;
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    wr(IDX_RELEASE_CFG, {t, c}, 2'h0);
    trg <= ~(4'h1 << t);
    tick(8);
    chk(rel_n, 1'b0);
    trg <= 4'hF;
    while (!rel_n && n < 400) begin
      n++;
      tick(1);
    end
    trg <= 4'h0;
    chk(n >= e && n <= e + 6, 1);
  endtask

  initial begin
    #100000;
    failures++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
    test_done;
  end

  initial begin
    int b;
    logic [1:0] m;
    logic sl;
    tick(4);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 12; i++) rd(regs[i], 34'h0);
    for (int i = 0; i < 12; i++) begin
      lf = nx(lf);
      wr(regs[i], lf[7:0] & msk[i], 2'h0);
      rd(regs[i], {26'h0, lf[7:0] & msk[i]});
    end
    wr(12'h0A1, 8'h5A, 2'h2);
    rd(12'h0A1, {2'h2, 32'h0});
    wr(IDX_STATUS, 8'h5A, 2'h2);
    $display("registers done");
    for (int i = 0; i < 12; i++) begin
      b = i / 4;
      m = i[1:0];
      lf = nx(lf);
      ba <= lf[9];
      slb <= lf[12:10];
      en <= lf[15:13];
      half <= lf[16];
      wr(cfg_i[b], {m, lf[0], 5'h00}, 2'h0);
      wr(va_i[b], lf[8:1], 2'h0);
      wr(il_i[b], {4'h0, lf[20:17]}, 2'h0);
      sl = lf[9] ? lf[10 + b] : lf[8];
      chk(drv[b][14:1], {m[0] | (m == 0 && sl), m[1] | (m == 0 && !sl),
        !lf[13 + b] && !lf[0], lf[7:1], lf[20:17]});
      if (b == 0) chk(drv[0].half_ilim, lf[16]);
    end
    $display("bucks done");
    walk(8'h52, 4'h5, 1'b0, 255, HB * 2, HB * 2 + 4);
    walk(8'h52, 4'h5, 1'b1, 255, 0, 0);
    walk(8'hD1, 4'h2, 1'b1, 255, HB, HB + 4);
    walk(8'hA0, 4'h3, 1'b1, 255, EL, EL + 5);
    walk(8'h40, 4'h6, 1'b0, 30, 31, 37);
    walk(8'h50, 4'h5, 1'b0, 255, 0, 0);
    $display("sequencer done");
    for (int i = 0; i < 5; i++) rel_test(i[1:0], codes[i]);
    // status after release: output high, release timer idle, pause idle
    rd(IDX_STATUS, 34'h8);
    $display("release done");
    tick(4);
    test_done;
  end
endmodule
